/* bench/cfg_host.sv */
// Host model that issues configuration reads and writes.
`timescale 1ns/1ns
module cfg_host (
    // Clock.
    input wire logic clk_sys,
    // Configuration request and answer.
    output vcfg_pkg::cfg_req_t cfg_req,
    input wire vcfg_pkg::cfg_rsp_t cfg_rsp
);
    import vcfg_pkg::*;
    initial cfg_req = '0;
    // One request held for one edge; the answer is taken 1 ns after that edge.
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [3:0] b, input logic [31:0] d, output cfg_rsp_t r);
        @(posedge clk_sys);
        cfg_req <= '{rd: !w, wr: w, addr: a, be: b, wdata: d};
        @(posedge clk_sys);
        cfg_req <= '0;
        #1 r = cfg_rsp;
    endtask
endmodule // cfg_host

/* bench/switch_vendor_config_regs_tb.sv */
// Self-checking bench for the vendor configuration register group.
`timescale 1ns/1ns
module switch_vendor_config_regs_tb;
    import vcfg_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [3:0] b;
        logic [31:0] d;
        logic h;
        logic [31:0] x;
    } row_t;
    logic clk_sys;
    logic rstn;
    logic l1_request;
    logic l1_enter;
    logic link_low_power_block;
    logic [15:0] subsys_identifier_field;
    logic [15:0] subsys_maker_code_field;
    eeprom_load_t eeprom_load;
    cfg_req_t cfg_req;
    cfg_rsp_t cfg_rsp;
    cfg_rsp_t r;
    int n_fail;
    int checked;
    row_t rows [13] = '{
        '{1'h0, OFS_RSVD_A, 4'h0, 32'h0, 1'h1, RST_RSVD_A},
        '{1'h0, OFS_RSVD_B, 4'h0, 32'h0, 1'h1, RST_RSVD_B},
        '{1'h0, OFS_RSVD_C, 4'h0, 32'h0, 1'h1, RST_RSVD_C},
        '{1'h0, OFS_SUBSYS, 4'h0, 32'h0, 1'h1, 32'h0},
        '{1'h0, OFS_GCTRL, 4'h0, 32'h0, 1'h1, 32'h0},
        '{1'h0, 8'hF0, 4'h0, 32'h0, 1'h0, 32'h0},
        '{1'h1, OFS_SUBSYS, 4'hF, 32'h1234_5678, 1'h1, 32'h0},
        '{1'h1, OFS_SUBSYS, 4'h3, 32'h0000_ABCD, 1'h1, 32'h0},
        '{1'h0, OFS_SUBSYS, 4'h0, 32'h0, 1'h1, 32'h1234_ABCD},
        '{1'h1, OFS_GCTRL, 4'hF, 32'hFFFF_FFFF, 1'h1, 32'h0},
        '{1'h0, OFS_GCTRL, 4'h0, 32'h0, 1'h1, 32'h0000_0006},
        '{1'h1, OFS_RSVD_A, 4'hF, 32'h0, 1'h1, 32'h0},
        '{1'h0, OFS_RSVD_A, 4'h0, 32'h0, 1'h1, 32'h0}
    };
    switch_vendor_config_regs i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .cfg_req(cfg_req),
        .cfg_rsp(cfg_rsp), .eeprom_load(eeprom_load),
        .l1_request(l1_request), .l1_enter(l1_enter),
        .subsys_identifier_field(subsys_identifier_field),
        .subsys_maker_code_field(subsys_maker_code_field),
        .link_low_power_block(link_low_power_block)
    );
    cfg_host i_host (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
    task automatic chk(input string s, input logic [33:0] e,
            input logic [33:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (1000) @(posedge clk_sys);
        n_fail++;
        print_verdict();
    end
    initial begin
        rstn = 1'h0;
        l1_request = 1'h0;
        eeprom_load = '0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'h1;
        foreach (rows[i]) begin
            i_host.xfer(rows[i].w, rows[i].a, rows[i].b, rows[i].d, r);
            chk("rsp", {1'h1, rows[i].h, rows[i].x}, r);
        end
        @(posedge clk_sys);
        l1_request <= 1'h1;
        repeat (2) @(posedge clk_sys);
        #1 chk("sid", 34'h1234, 34'(subsys_identifier_field));
        chk("svid", 34'hABCD, 34'(subsys_maker_code_field));
        chk("block", 34'h1, 34'(link_low_power_block));
        chk("l1", 34'h0, 34'(l1_enter));
        i_host.xfer(1'h1, OFS_GCTRL, 4'hF, 32'h0, r);
        @(posedge clk_sys);
        #1 chk("l1", 34'h1, 34'(l1_enter));
        @(posedge clk_sys);
        eeprom_load <= '{load: 1'h1, data: 32'h55AA_33CC};
        l1_request <= 1'h0;
        @(posedge clk_sys);
        eeprom_load <= '0;
        i_host.xfer(1'h0, OFS_SUBSYS, 4'h0, 32'h0, r);
        chk("load", {2'h3, 32'h55AA_33CC}, r);
        @(posedge clk_sys);
        rstn <= 1'h0;
        #1 chk("sid", 34'h0, 34'(subsys_identifier_field));
        repeat (20) @(posedge clk_sys);
        rstn <= 1'h1;
        i_host.xfer(1'h0, OFS_RSVD_A, 4'h0, 32'h0, r);
        chk("rsvd", {2'h3, RST_RSVD_A}, r);
        i_host.xfer(1'h0, OFS_SUBSYS, 4'h0, 32'h0, r);
        chk("subsys", {2'h3, 32'h0}, r);
        print_verdict();
    end
endmodule // switch_vendor_config_regs_tb

/* core/switch_vendor_config_regs.sv */
// Vendor configuration register group of the switch upstream port.
`timescale 1ns/1ns
module switch_vendor_config_regs (
    // Clock and fundamental reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Configuration request and answer.
    input wire vcfg_pkg::cfg_req_t cfg_req,
    output vcfg_pkg::cfg_rsp_t cfg_rsp,
    // EEPROM preload of the subsystem register.
    input wire vcfg_pkg::eeprom_load_t eeprom_load,
    // Link power management.
    input wire logic l1_request,
    output logic l1_enter,
    // Mirrored subsystem identifiers for all ports, and the low power block bit.
    output logic [15:0] subsys_identifier_field,
    output logic [15:0] subsys_maker_code_field,
    output logic link_low_power_block
);
    import vcfg_pkg::*;

    // Positions of the words in the register array.
    localparam int IDX_RSVD_A = 0;
    localparam int IDX_SUBSYS = 3;
    localparam int IDX_GCTRL = 4;

    localparam logic [31:0] RST_VAL [NUM_REGS] =
        '{RST_RSVD_A, RST_RSVD_B, RST_RSVD_C, RST_SUBSYS, RST_GCTRL};
    localparam logic [31:0] WMASK [NUM_REGS] =
        '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
          GCTRL_WMASK};
    localparam logic [7:0] OFS [NUM_REGS] =
        '{OFS_RSVD_A, OFS_RSVD_B, OFS_RSVD_C, OFS_SUBSYS, OFS_GCTRL};

    // Register array and address decode.
    logic [31:0] word [NUM_REGS];
    logic [NUM_REGS-1:0] sel;
    logic req_any;
    logic link_block_bit;

    // Configuration answer.
    cfg_rsp_t rsp_next;
    cfg_rsp_t rsp_reg;

    // Subsystem identifier mirror.
    logic [15:0] sid_next;
    logic [15:0] svid_next;
    logic [15:0] sid_reg;
    logic [15:0] svid_reg;

    // Link power management.
    logic block_next;
    logic l1_next;
    logic block_reg;
    logic l1_reg;

    assign req_any = cfg_req.rd || cfg_req.wr;
    assign link_block_bit = word[IDX_GCTRL][GCTRL_LINK_BLOCK_BIT];

    // One word per register; reset restores each default.
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_regs
        assign sel[g] = (cfg_req.addr == OFS[g]);
        vcfg_reg_word #(
            .RESET_VAL(RST_VAL[g]),
            .WMASK(WMASK[g])
        ) u_word (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .wr_en(cfg_req.wr && sel[g]),
            .be(cfg_req.be),
            .wdata(cfg_req.wdata),
            .load_en((g == IDX_SUBSYS) && eeprom_load.load),
            .load_data(eeprom_load.data),
            .value_reg(word[g])
        );
    end

    // One registered answer per request; no data on writes or misses.
    always_comb begin
        rsp_next = '0;
        rsp_next.valid = req_any;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (sel[i] && req_any) begin
                rsp_next.hit = 1'h1;
                if (cfg_req.rd) begin
                    rsp_next.rdata = word[i] & WMASK[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    // Both halves of the subsystem word feed the identifier views.
    always_comb begin
        sid_next = word[IDX_SUBSYS][31:SUBSYS_ID_LSB];
        svid_next = word[IDX_SUBSYS][SUBSYS_ID_LSB-1:0];
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sid_reg <= '0;
            svid_reg <= '0;
        end else begin
            sid_reg <= sid_next;
            svid_reg <= svid_next;
        end
    end

    // The block bit holds back every request to enter L1.
    always_comb begin
        block_next = link_block_bit;
        l1_next = l1_request && !link_block_bit;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            block_reg <= 1'h0;
            l1_reg <= 1'h0;
        end else begin
            block_reg <= block_next;
            l1_reg <= l1_next;
        end
    end

    assign cfg_rsp = rsp_reg;
    assign subsys_identifier_field = sid_reg;
    assign subsys_maker_code_field = svid_reg;
    assign link_low_power_block = block_reg;
    assign l1_enter = l1_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Link power and mirror checks.
    l1_blocked_a: assert property (
        link_block_bit |=> !l1_enter)
        else $error("L1 entry while blocked");

    l1_pass_a: assert property (
        l1_request && !link_block_bit |=> l1_enter)
        else $error("L1 entry not passed");

    block_mirror_a: assert property (
        ##1 link_low_power_block == $past(link_block_bit))
        else $error("low power block output wrong");

    sid_mirror_a: assert property (
        ##1 subsys_identifier_field ==
        $past(word[IDX_SUBSYS][31:SUBSYS_ID_LSB]))
        else $error("subsystem identifier mirror wrong");

    svid_mirror_a: assert property (
        ##1 subsys_maker_code_field ==
        $past(word[IDX_SUBSYS][SUBSYS_ID_LSB-1:0]))
        else $error("subsystem maker code mirror wrong");

    // Register write, preload and read-mask checks.
    gctrl_zero_a: assert property (
        cfg_req.rd && sel[IDX_GCTRL] |=>
        (cfg_rsp.rdata & ~GCTRL_WMASK) == 32'h0)
        else $error("control reserved bits read nonzero");

    gctrl_write_a: assert property (
        cfg_req.wr && sel[IDX_GCTRL] && cfg_req.be[0] |=>
        word[IDX_GCTRL] == ($past(cfg_req.wdata) & GCTRL_WMASK))
        else $error("control write lost");

    eeprom_load_a: assert property (
        eeprom_load.load && !(cfg_req.wr && sel[IDX_SUBSYS]) |=>
        word[IDX_SUBSYS] == $past(eeprom_load.data))
        else $error("subsystem preload lost");

    write_wins_a: assert property (
        cfg_req.wr && sel[IDX_SUBSYS] && cfg_req.be == 4'hF |=>
        word[IDX_SUBSYS] == $past(cfg_req.wdata))
        else $error("subsystem write lost");

    lane_keep_a: assert property (
        cfg_req.wr && sel[IDX_SUBSYS] && !cfg_req.be[3] &&
        !eeprom_load.load |=> word[IDX_SUBSYS][31:24] ==
        $past(word[IDX_SUBSYS][31:24]))
        else $error("disabled byte lane changed");

    write_word_a: assert property (
        cfg_req.wr && sel[IDX_RSVD_A] && cfg_req.be == 4'hF |=>
        word[IDX_RSVD_A] == $past(cfg_req.wdata))
        else $error("full word write lost");

    // Answer checks.
    read_answer_a: assert property (
        cfg_req.rd && sel[IDX_RSVD_A] |=> cfg_rsp.valid &&
        cfg_rsp.hit && cfg_rsp.rdata == $past(word[IDX_RSVD_A]))
        else $error("read answer wrong");

    hit_answer_a: assert property (
        req_any && sel[IDX_SUBSYS] |=>
        cfg_rsp.valid && cfg_rsp.hit)
        else $error("mapped answer without hit");

    miss_answer_a: assert property (
        req_any && sel == '0 |=> cfg_rsp.valid && !cfg_rsp.hit &&
        cfg_rsp.rdata == 32'h0)
        else $error("unmapped answer wrong");

    idle_answer_a: assert property (
        !req_any |=> !cfg_rsp.valid && !cfg_rsp.hit)
        else $error("answer without request");

    write_data_a: assert property (
        cfg_req.wr && !cfg_req.rd |=> cfg_rsp.rdata == 32'h0)
        else $error("write answer carries data");

    // Main scenarios.
    read_cov: cover property (cfg_req.rd && sel[IDX_SUBSYS]);
    block_cov: cover property (l1_request && link_block_bit);
    load_cov: cover property (eeprom_load.load);
    write_cov: cover property (cfg_req.wr && sel[IDX_GCTRL]);
    unblock_cov: cover property (l1_request && !link_block_bit);
endmodule // switch_vendor_config_regs

/* core/vcfg_pkg.sv */
// Constants and types for the switch vendor configuration register group.
// Operation
// - Reserved registers reload defaults on fundamental reset.
// - Subsystem register mirrors into every port's identifiers.
// - Bits 31:16 appear as subsystem identifier.
// - Bits 15:0 appear as subsystem maker code.
// - Subsystem fields reset zero, then EEPROM loads.
// - General control register resets zero, mixed access.
// - Low power block bit stops L1 entry.
// - Control bits 31:3 and 0 read zero.
package vcfg_pkg;
    localparam logic [7:0] OFS_RSVD_A = 8'hD4;
    localparam logic [7:0] OFS_RSVD_B = 8'hD8;
    localparam logic [7:0] OFS_RSVD_C = 8'hDC;
    localparam logic [7:0] OFS_SUBSYS = 8'hE0;
    localparam logic [7:0] OFS_GCTRL = 8'hE4;
    localparam logic [7:0] OFS_SUBSYS_MIRROR = 8'h84;
    localparam logic [31:0] RST_RSVD_A = 32'h0000_0010;
    localparam logic [31:0] RST_RSVD_B = 32'h0000_0000;
    localparam logic [31:0] RST_RSVD_C = 32'h0000_0002;
    localparam logic [31:0] RST_SUBSYS = 32'h0000_0000;
    localparam logic [31:0] RST_GCTRL = 32'h0000_0000;
    localparam logic [31:0] GCTRL_WMASK = 32'h0000_0006;
    localparam int GCTRL_LINK_BLOCK_BIT = 1;
    localparam int GCTRL_VENDOR_BIT = 2;
    localparam int SUBSYS_ID_LSB = 16;
    localparam int NUM_REGS = 5;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic load;
        logic [31:0] data;
    } eeprom_load_t;
endpackage

/* core/vcfg_reg_word.sv */
// One 32-bit configuration word with byte-enable writes and a preload.
`timescale 1ns/1ns
module vcfg_reg_word #(
    parameter logic [31:0] RESET_VAL = 32'h0000_0000,
    parameter logic [31:0] WMASK = 32'hFFFF_FFFF
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Write side.
    input wire logic wr_en,
    input wire logic [3:0] be,
    input wire logic [31:0] wdata,
    input wire logic load_en,
    input wire logic [31:0] load_data,
    // Stored value.
    output logic [31:0] value_reg
);
    logic [31:0] value_next;

    always_comb begin
        value_next = value_reg;
        if (load_en) begin
            value_next = load_data & WMASK;
        end
        if (wr_en) begin
            for (int i = 0; i < 4; i++) begin
                if (be[i]) begin
                    value_next[i*8 +: 8] = (wdata[i*8 +: 8] & WMASK[i*8 +: 8])
                        | (value_reg[i*8 +: 8] & ~WMASK[i*8 +: 8]);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            value_reg <= RESET_VAL;
        end else begin
            value_reg <= value_next;
        end
    end
endmodule // vcfg_reg_word
